// file: include/pwmtu_pkg.sv
// ==========================================
// Three-phase PWM timing unit constants
package pwmtu_pkg;
	// ==========================================
	// Widths
	localparam int CNT_W = 16;
	localparam int DT_W = 10;
	localparam int SW_W = 8;
	localparam int SEG_W = 9;
	localparam int ADDR_W = 4;
	localparam int PRE_W = 18;
	// ==========================================
	// Register word addresses
	localparam logic [3:0] ADDR_HALF_PERIOD = 4'h0;
	localparam logic [3:0] ADDR_DEAD_TIME = 4'h1;
	localparam logic [3:0] ADDR_MIN_PULSE = 4'h2;
	localparam logic [3:0] ADDR_SYNC_WIDTH = 4'h3;
	localparam logic [3:0] ADDR_DUTY_A = 4'h4;
	localparam logic [3:0] ADDR_DUTY_B = 4'h5;
	localparam logic [3:0] ADDR_DUTY_C = 4'h6;
	localparam logic [3:0] ADDR_SEGMENT = 4'h7;
	localparam logic [3:0] ADDR_MODE = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'h9;
	// ==========================================
	// Reset values
	localparam logic [15:0] RST_HALF_PERIOD = 16'h0000;
	localparam logic [9:0] RST_DEAD_TIME = 10'h000;
	localparam logic [15:0] RST_MIN_PULSE = 16'h0000;
	localparam logic [7:0] RST_SYNC_WIDTH = 8'h27;
	localparam logic [15:0] RST_DUTY = 16'h0000;
	localparam logic [8:0] RST_SEGMENT = 9'h000;
	localparam logic [15:0] RST_MODE = 16'h0000;
	// ==========================================
	// Field positions
	localparam int MODE_DOUBLE_BIT = 6;
	localparam int STATUS_RUN_BIT = 0;
	localparam int STATUS_HALF_BIT = 3;
	localparam int SEG_DIS_BASE = 0;
	localparam int SEG_XOVER_BASE = 6;
endpackage : pwmtu_pkg

// file: rtl/pwmtu_phase_cmp.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Center-based compare for one phase pair
module pwmtu_phase_cmp (
	// Distance from period center and active settings
	input wire logic [15:0] cnt_in,
	input wire logic [15:0] duty_in,
	input wire logic [9:0] dt_in,
	// Raw pair before output control
	output logic high_out,
	output logic low_out
);
	logic [17:0] hi_th;
	logic [16:0] lo_th;

	// edges moved dt each way, no gap at zero
	assign hi_th = {2'b00, duty_in} - {8'h00, dt_in};
	assign lo_th = {1'b0, duty_in} + {7'h00, dt_in};
	assign high_out = $signed({2'b00, cnt_in}) < $signed(hi_th);
	assign low_out = {1'b0, cnt_in} >= lo_th;
endmodule : pwmtu_phase_cmp
`default_nettype wire

// file: rtl/pwmtu_sync_gen.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Sync pulse of width+1 clocks
module pwmtu_sync_gen (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Start request and width
	input wire logic start_in,
	input wire logic [7:0] width_in,
	// Pulse
	output logic pulse_out
);
	logic pulse_ff;
	logic [7:0] rem_ff;

	// Pulse stays high for width+1 cycles after start
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pulse_ff <= 1'b0;
			rem_ff <= 8'h00;
		end else if (start_in) begin
			pulse_ff <= 1'b1;
			rem_ff <= width_in;
		end else if (pulse_ff) begin
			if (rem_ff == 8'h00) begin
				pulse_ff <= 1'b0;
			end else begin
				rem_ff <= rem_ff - 8'h01;
			end
		end
	end

	assign pulse_out = pulse_ff;
endmodule : pwmtu_sync_gen
`default_nettype wire

// file: rtl/pwmtu_timing_unit.sv
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/10ps
`default_nettype none
module pwmtu_timing_unit (
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	// Register port
	input wire logic [3:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	// Sync pulse to converter sequencing and processor
	output logic period_sync_pulse_out,
	// Gate drive outputs
	output logic phase_a_high_out,
	output logic phase_a_low_out,
	output logic phase_b_high_out,
	output logic phase_b_low_out,
	output logic phase_c_high_out,
	output logic phase_c_low_out
);
	// ==========================================
	// Reset release
	logic rst_meta_ff;
	logic rst_n_ff;

	// Two stage release of the external reset
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff <= rst_meta_ff;
		end
	end

	// ==========================================
	// Software registers
	logic [15:0] half_period_count_ff;
	logic [9:0] dead_time_count_ff;
	logic [15:0] minimum_pulse_count_ff;
	logic [7:0] sync_pulse_width_ff;
	logic [15:0] duty_ff [3];
	logic [8:0] output_segment_control_ff;
	logic [15:0] mode_control_register_ff;
	logic [15:0] system_status_register;
	logic [15:0] nxt_rdata;
	logic [15:0] rdata_ff;
	logic wr_tm;
	logic double_mode;

	assign wr_tm = wr_in && (addr_in == pwmtu_pkg::ADDR_HALF_PERIOD);
	assign double_mode = mode_control_register_ff[pwmtu_pkg::MODE_DOUBLE_BIT];

	// Register writes
	always_ff @(posedge sys_clk_in or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			half_period_count_ff <= pwmtu_pkg::RST_HALF_PERIOD;
			dead_time_count_ff <= pwmtu_pkg::RST_DEAD_TIME;
			minimum_pulse_count_ff <= pwmtu_pkg::RST_MIN_PULSE;
			sync_pulse_width_ff <= pwmtu_pkg::RST_SYNC_WIDTH;
			duty_ff[0] <= pwmtu_pkg::RST_DUTY;
			duty_ff[1] <= pwmtu_pkg::RST_DUTY;
			duty_ff[2] <= pwmtu_pkg::RST_DUTY;
			output_segment_control_ff <= pwmtu_pkg::RST_SEGMENT;
			mode_control_register_ff <= pwmtu_pkg::RST_MODE;
		end else if (wr_in) begin
			unique case (addr_in)
				pwmtu_pkg::ADDR_HALF_PERIOD: half_period_count_ff <= wdata_in;
				pwmtu_pkg::ADDR_DEAD_TIME: dead_time_count_ff <= wdata_in[9:0];
				pwmtu_pkg::ADDR_MIN_PULSE: minimum_pulse_count_ff <= wdata_in;
				pwmtu_pkg::ADDR_SYNC_WIDTH: sync_pulse_width_ff <= wdata_in[7:0];
				pwmtu_pkg::ADDR_DUTY_A: duty_ff[0] <= wdata_in;
				pwmtu_pkg::ADDR_DUTY_B: duty_ff[1] <= wdata_in;
				pwmtu_pkg::ADDR_DUTY_C: duty_ff[2] <= wdata_in;
				pwmtu_pkg::ADDR_SEGMENT: output_segment_control_ff <= wdata_in[8:0];
				pwmtu_pkg::ADDR_MODE: mode_control_register_ff <= wdata_in;
				default: begin
				end
			endcase
		end
	end

	// ==========================================
	// Start-up hold-off
	logic [3:0] written_ff;
	logic tm_first_ff;
	logic [17:0] pre_cnt_ff;
	logic [17:0] pre_target;
	logic running_ff;
	logic start_now;

	always_ff @(posedge sys_clk_in or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			written_ff <= 4'h0;
		end else if (wr_in) begin
			if (addr_in == pwmtu_pkg::ADDR_HALF_PERIOD) begin
				written_ff[0] <= 1'b1;
			end
			if (addr_in == pwmtu_pkg::ADDR_DUTY_A) begin
				written_ff[1] <= 1'b1;
			end
			if (addr_in == pwmtu_pkg::ADDR_DUTY_B) begin
				written_ff[2] <= 1'b1;
			end
			if (addr_in == pwmtu_pkg::ADDR_DUTY_C) begin
				written_ff[3] <= 1'b1;
			end
		end
	end

	// delay of 1.5 or 1 half periods
	assign pre_target = double_mode ? {2'b00, half_period_count_ff}
		: {2'b00, half_period_count_ff} + {3'b000, half_period_count_ff[15:1]};

	// Main timer runs from the first half-period write
	always_ff @(posedge sys_clk_in or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			tm_first_ff <= 1'b0;
			pre_cnt_ff <= 18'h00000;
		end else if (wr_tm && !tm_first_ff) begin
			tm_first_ff <= 1'b1;
			pre_cnt_ff <= 18'h00001;
		end else if (tm_first_ff && !running_ff && pre_cnt_ff < pre_target) begin
			pre_cnt_ff <= pre_cnt_ff + 18'h00001;
		end
	end

	// enable once half period and all three duties written and delay expired
	assign start_now = !running_ff && (&written_ff) && tm_first_ff && (pre_cnt_ff >= pre_target);

	// ==========================================
	// Half-period counter and parameter latch
	logic [15:0] cnt_ff;
	logic half_ff;
	logic [15:0] tm_act_ff;
	logic [9:0] dt_act_ff;
	logic [15:0] pd_act_ff;
	logic [7:0] sw_act_ff;
	logic [15:0] duty_act_ff [3];
	logic [8:0] seg_act_ff;
	logic first_end;
	logic second_end;
	logic load_now;

	assign first_end = !half_ff && (cnt_ff == 16'h0000);
	assign second_end = half_ff && (({1'b0, cnt_ff} + 17'h00001) >= {1'b0, tm_act_ff});
	// load at period start, also at midpoint in double mode
	assign load_now = start_now || (running_ff && (second_end || (first_end && double_mode)));

	// down in first half, up in second half
	always_ff @(posedge sys_clk_in or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			running_ff <= 1'b0;
			half_ff <= 1'b0;
			cnt_ff <= 16'h0000;
		end else if (start_now || (running_ff && second_end)) begin
			running_ff <= 1'b1;
			half_ff <= 1'b0;
			cnt_ff <= half_period_count_ff - 16'h0001;
		end else if (running_ff && first_end) begin
			half_ff <= 1'b1;
			cnt_ff <= 16'h0000;
		end else if (running_ff) begin
			cnt_ff <= half_ff ? cnt_ff + 16'h0001 : cnt_ff - 16'h0001;
		end
	end

	// latch shadow counts on sync edge
	always_ff @(posedge sys_clk_in or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			tm_act_ff <= pwmtu_pkg::RST_HALF_PERIOD;
			dt_act_ff <= pwmtu_pkg::RST_DEAD_TIME;
			pd_act_ff <= pwmtu_pkg::RST_MIN_PULSE;
			sw_act_ff <= pwmtu_pkg::RST_SYNC_WIDTH;
			duty_act_ff[0] <= pwmtu_pkg::RST_DUTY;
			duty_act_ff[1] <= pwmtu_pkg::RST_DUTY;
			duty_act_ff[2] <= pwmtu_pkg::RST_DUTY;
			seg_act_ff <= pwmtu_pkg::RST_SEGMENT;
		end else if (load_now) begin
			// in double mode each half takes its own dead time; otherwise both halves share one
			tm_act_ff <= half_period_count_ff;
			dt_act_ff <= dead_time_count_ff;
			pd_act_ff <= minimum_pulse_count_ff;
			sw_act_ff <= sync_pulse_width_ff;
			duty_act_ff[0] <= duty_ff[0];
			duty_act_ff[1] <= duty_ff[1];
			duty_act_ff[2] <= duty_ff[2];
			seg_act_ff <= output_segment_control_ff;
		end
	end

	// ==========================================
	// Sync pulse
	logic sync_pulse;

	// width plus one clocks, one per load
	pwmtu_sync_gen u_sync (
		.clk_in(sys_clk_in),
		.rstn_in(rst_n_ff),
		.start_in(load_now),
		.width_in(sync_pulse_width_ff),
		.pulse_out(sync_pulse)
	);

	always_ff @(posedge sys_clk_in or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			period_sync_pulse_out <= 1'b0;
		end else begin
			period_sync_pulse_out <= sync_pulse;
		end
	end

	// ==========================================
	// Phase pairs
	logic [2:0] raw_high;
	logic [2:0] raw_low;
	logic [5:0] out_ff;

	for (genvar p = 0; p < 3; p++) begin : g_phase
		logic x_hi;
		logic x_lo;
		logic dis_hi;
		logic dis_lo;

		pwmtu_phase_cmp u_cmp (
			.cnt_in(cnt_ff),
			.duty_in(duty_act_ff[p]),
			.dt_in(dt_act_ff),
			.high_out(raw_high[p]),
			.low_out(raw_low[p])
		);

		// Crossover swaps the pair, disable gates afterwards
		assign x_hi = seg_act_ff[pwmtu_pkg::SEG_XOVER_BASE + 2 - p] ? raw_low[p] : raw_high[p];
		assign x_lo = seg_act_ff[pwmtu_pkg::SEG_XOVER_BASE + 2 - p] ? raw_high[p] : raw_low[p];
		assign dis_hi = seg_act_ff[pwmtu_pkg::SEG_DIS_BASE + 5 - 2 * p];
		assign dis_lo = seg_act_ff[pwmtu_pkg::SEG_DIS_BASE + 4 - 2 * p];

		always_ff @(posedge sys_clk_in or negedge rst_n_ff) begin
			if (!rst_n_ff) begin
				out_ff[2 * p + 1] <= 1'b0;
				out_ff[2 * p] <= 1'b0;
			end else begin
				out_ff[2 * p + 1] <= running_ff && x_hi && !dis_hi;
				out_ff[2 * p] <= running_ff && x_lo && !dis_lo;
			end
		end
	end

	assign phase_a_high_out = out_ff[1];
	assign phase_a_low_out = out_ff[0];
	assign phase_b_high_out = out_ff[3];
	assign phase_b_low_out = out_ff[2];
	assign phase_c_high_out = out_ff[5];
	assign phase_c_low_out = out_ff[4];

	// ==========================================
	// Read path
	// half flag and run state in status
	always_comb begin
		system_status_register = 16'h0000;
		system_status_register[pwmtu_pkg::STATUS_RUN_BIT] = running_ff;
		system_status_register[pwmtu_pkg::STATUS_HALF_BIT] = half_ff;
	end

	// Read mux, unmapped reads zero
	always_comb begin
		nxt_rdata = 16'h0000;
		unique case (addr_in)
			pwmtu_pkg::ADDR_HALF_PERIOD: nxt_rdata = half_period_count_ff;
			pwmtu_pkg::ADDR_DEAD_TIME: nxt_rdata = {6'h00, dead_time_count_ff};
			pwmtu_pkg::ADDR_MIN_PULSE: nxt_rdata = minimum_pulse_count_ff;
			pwmtu_pkg::ADDR_SYNC_WIDTH: nxt_rdata = {8'h00, sync_pulse_width_ff};
			pwmtu_pkg::ADDR_DUTY_A: nxt_rdata = duty_ff[0];
			pwmtu_pkg::ADDR_DUTY_B: nxt_rdata = duty_ff[1];
			pwmtu_pkg::ADDR_DUTY_C: nxt_rdata = duty_ff[2];
			pwmtu_pkg::ADDR_SEGMENT: nxt_rdata = {7'h00, output_segment_control_ff};
			pwmtu_pkg::ADDR_MODE: nxt_rdata = mode_control_register_ff;
			pwmtu_pkg::ADDR_STATUS: nxt_rdata = system_status_register;
			default: nxt_rdata = 16'h0000;
		endcase
	end

	// Read data stands only the cycle after the strobe
	always_ff @(posedge sys_clk_in or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			rdata_ff <= 16'h0000;
		end else begin
			rdata_ff <= rd_in ? nxt_rdata : 16'h0000;
		end
	end

	assign rdata_out = rdata_ff;

	// Minimum pulse and width copies are unused; the pulse generator takes the written sync width directly
	logic unused_pd;
	assign unused_pd = ^{pd_act_ff, sw_act_ff};
endmodule : pwmtu_timing_unit
`default_nettype wire

// file: verification/pwmtu_gate_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Inverter legs: count cycles with both switches of a leg on
module pwmtu_gate_model (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rstn_in,
	// Gate drives, phase A high side first
	input wire logic [5:0] gate_in,
	// Shoot-through cycles seen
	output logic [15:0] fault_cnt_out
);
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			fault_cnt_out <= 16'h0000;
		end else if ((gate_in[5] & gate_in[4]) | (gate_in[3] & gate_in[2]) | (gate_in[1] & gate_in[0])) begin
			fault_cnt_out <= fault_cnt_out + 16'h0001;
		end
	end
endmodule : pwmtu_gate_model
`default_nettype wire

// file: verification/pwmtu_timing_unit_checker.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port checks for the timing unit
module pwmtu_timing_unit_checker (
	// Clock, reset and register port
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic [3:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	input wire logic [15:0] rdata_out,
	// Sync and gate drives
	input wire logic period_sync_pulse_out,
	input wire logic phase_a_high_out,
	input wire logic phase_a_low_out,
	input wire logic phase_b_high_out,
	input wire logic phase_b_low_out,
	input wire logic phase_c_high_out,
	input wire logic phase_c_low_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	logic [9:0] sync_len_ff;
	logic sw_wr_ff;
	logic [3:0] seen_ff;
	// Sync high length, width written, init writes seen
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sync_len_ff <= 10'h000;
			sw_wr_ff <= 1'b0;
			seen_ff <= 4'h0;
		end else begin
			sync_len_ff <= period_sync_pulse_out ? sync_len_ff + 10'h001 : 10'h000;
			if (wr_in && addr_in == pwmtu_pkg::ADDR_SYNC_WIDTH) sw_wr_ff <= 1'b1;
			if (wr_in && addr_in == pwmtu_pkg::ADDR_HALF_PERIOD) seen_ff[0] <= 1'b1;
			if (wr_in && addr_in == pwmtu_pkg::ADDR_DUTY_A) seen_ff[1] <= 1'b1;
			if (wr_in && addr_in == pwmtu_pkg::ADDR_DUTY_B) seen_ff[2] <= 1'b1;
			if (wr_in && addr_in == pwmtu_pkg::ADDR_DUTY_C) seen_ff[3] <= 1'b1;
		end
	end
	sequence s_mode_wr; wr_in && addr_in == pwmtu_pkg::ADDR_MODE; endsequence
	sequence s_mode_rd; rd_in && addr_in == pwmtu_pkg::ADDR_MODE; endsequence
	property p_a_excl; !(phase_a_high_out && phase_a_low_out); endproperty
	a_a_excl: assert property (p_a_excl) else $error("phase A pair overlap");
	property p_b_excl; !(phase_b_high_out && phase_b_low_out); endproperty
	a_b_excl: assert property (p_b_excl) else $error("phase B pair overlap");
	property p_c_excl; !(phase_c_high_out && phase_c_low_out); endproperty
	a_c_excl: assert property (p_c_excl) else $error("phase C pair overlap");
	property p_dt_width; rd_in && addr_in == pwmtu_pkg::ADDR_DEAD_TIME |=> rdata_out[15:10] == 6'h00; endproperty
	a_dt_width: assert property (p_dt_width) else $error("dead time wider than ten bits");
	property p_mode_rb; s_mode_wr ##2 s_mode_rd |=> rdata_out[6] == $past(wdata_in[6], 3); endproperty
	a_mode_rb: assert property (p_mode_rb) else $error("mode bit not kept");
	property p_quiet;
		seen_ff != 4'hf |-> !(period_sync_pulse_out || phase_a_high_out || phase_a_low_out
			|| phase_b_high_out || phase_b_low_out || phase_c_high_out || phase_c_low_out);
	endproperty
	a_quiet: assert property (p_quiet) else $error("output before setup");
	property p_sync_max; sync_len_ff <= 10'h100; endproperty
	a_sync_max: assert property (p_sync_max) else $error("sync too long");
	property p_sync_dflt; $fell(period_sync_pulse_out) && !sw_wr_ff |-> sync_len_ff == 10'h028; endproperty
	a_sync_dflt: assert property (p_sync_dflt) else $error("default sync width wrong");
endmodule : pwmtu_timing_unit_checker
`default_nettype wire

// file: verification/pwmtu_timing_unit_test.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Self-checking bench for the timing unit
module pwmtu_timing_unit_test;
	logic sys_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic [3:0] addr_in = 4'h0;
	logic [15:0] wdata_in = 16'h0000;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [15:0] rdata_out;
	logic sync;
	logic [5:0] gates;
	logic [15:0] faults;
	logic [15:0] v;
	logic x;
	int n_mismatch = 0;
	int n_tests = 0;
	int seed = 70;
	int cyc = 0;
	int hc[6];
	int per;
	int sw;
	int t0;
	int tm = 200;
	// Clock and cycle count
	always #2.5 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) cyc <= cyc + 1;
	pwmtu_timing_unit i_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.period_sync_pulse_out(sync), .phase_a_high_out(gates[5]), .phase_a_low_out(gates[4]),
		.phase_b_high_out(gates[3]), .phase_b_low_out(gates[2]), .phase_c_high_out(gates[1]),
		.phase_c_low_out(gates[0]));
	pwmtu_gate_model i_gate (.clk_in(sys_clk_in), .rstn_in(rstn_in), .gate_in(gates), .fault_cnt_out(faults));
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge sys_clk_in);
		wr_in <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge sys_clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge sys_clk_in);
		rd_in <= 1'b0;
		#1 d = rdata_out;
	endtask : rd
	task automatic rise();
		logic q;
		do begin
			q = sync;
			@(negedge sys_clk_in);
		end while (!(sync && !q));
	endtask : rise
	// Count gate and sync cycles over n sync intervals
	task automatic meas(input int n);
		logic q;
		per = 0;
		sw = 0;
		hc = '{default: 0};
		rise();
		repeat (n) begin
			do begin
				per++;
				sw += sync;
				foreach (hc[i]) hc[i] += gates[i];
				q = sync;
				@(negedge sys_clk_in);
			end while (!(sync && !q));
		end
	endtask : meas
	// Model: clamped on-time over two halves
	function automatic int on_t(int d, int dt, int t);
		int y;
		y = d - dt;
		if (y < 0) y = 0;
		if (y > t) y = t;
		return 2 * y;
	endfunction : on_t
	task automatic run_case(input int dt, input int w, input int dbl, input int d0, input int d1, input int d2);
		int d[3];
		d = '{d0, d1, d2};
		wr(pwmtu_pkg::ADDR_DEAD_TIME, 16'(dt));
		wr(pwmtu_pkg::ADDR_SYNC_WIDTH, 16'(w));
		wr(pwmtu_pkg::ADDR_MODE, dbl ? 16'h0040 : 16'h0000);
		foreach (d[p]) wr(pwmtu_pkg::ADDR_DUTY_A + 4'(p), 16'(d[p]));
		rise();
		rise();
		meas(dbl + 1);
		chk("period", per, 2 * tm);
		chk("sync width", sw, (dbl + 1) * (w + 1));
		foreach (d[p]) begin
			chk("high time", hc[5 - 2 * p], on_t(d[p], dt, tm));
			chk("low time", hc[4 - 2 * p], on_t(tm - d[p], dt, tm));
		end
	endtask : run_case
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test
	// Watchdog
	initial begin
		#400000;
		n_mismatch++;
		end_of_test();
	end
	// Main sequence
	initial begin
		repeat (8) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		rd(pwmtu_pkg::ADDR_SYNC_WIDTH, v);
		chk("sync width reset", v, 16'h0027);
		rd(pwmtu_pkg::ADDR_MODE, v);
		chk("mode reset", v, 16'h0000);
		rd(4'hf, v);
		chk("unmapped", v, 16'h0000);
		wr(pwmtu_pkg::ADDR_STATUS, 16'hffff);
		rd(pwmtu_pkg::ADDR_STATUS, v);
		chk("status idle", v, 16'h0000);
		wr(pwmtu_pkg::ADDR_DEAD_TIME, 16'hffff);
		rd(pwmtu_pkg::ADDR_DEAD_TIME, v);
		chk("dead time", v, 16'h03ff);
		wr(pwmtu_pkg::ADDR_MODE, 16'h0040);
		rd(pwmtu_pkg::ADDR_MODE, v);
		chk("mode bit", v[6], 1'b1);
		wr(pwmtu_pkg::ADDR_MODE, 16'h0000);
		wr(pwmtu_pkg::ADDR_HALF_PERIOD, 16'(tm));
		t0 = cyc;
		wr(pwmtu_pkg::ADDR_DEAD_TIME, 16'h0003);
		wr(pwmtu_pkg::ADDR_DUTY_A, 16'h0032);
		wr(pwmtu_pkg::ADDR_DUTY_B, 16'h0064);
		wr(pwmtu_pkg::ADDR_DUTY_C, 16'h0096);
		rise();
		chk("first sync", (cyc - t0 >= 300) && (cyc - t0 <= 306), 1'b1);
		meas(1);
		chk("default sync", sw, 40);
		run_case(0, 0, 0, 60, 120, 199);
		run_case(1023, 255, 0, 100, 20, 180);
		run_case(5, 9, 0, 3, 210, 0);
		for (int k = 0; k < 4; k++) begin
			run_case({$random(seed)} % 8, {$random(seed)} % 16, k % 2,
				{$random(seed)} % 201, {$random(seed)} % 201, {$random(seed)} % 201);
		end
		run_case(2, 7, 1, 30, 100, 170);
		rise();
		rd(pwmtu_pkg::ADDR_STATUS, v);
		x = v[3];
		rise();
		rd(pwmtu_pkg::ADDR_STATUS, v);
		chk("half flag", v[3] ^ x, 1'b1);
		// Segment control: phase A high disabled, phase C crossed over
		wr(pwmtu_pkg::ADDR_MODE, 16'h0000);
		wr(pwmtu_pkg::ADDR_SEGMENT, 16'h0060);
		rise();
		rise();
		meas(1);
		chk("segment disable", hc[5], 0);
		chk("segment crossover high", hc[1], on_t(tm - 170, 2, tm));
		chk("segment crossover low", hc[0], on_t(170, 2, tm));
		chk("shoot-through", faults, 16'h0000);
		// Mid-run reset, then start-up in double update
		@(posedge sys_clk_in);
		rstn_in <= 1'b0;
		repeat (8) @(posedge sys_clk_in);
		rstn_in <= 1'b1;
		repeat (3) @(posedge sys_clk_in);
		wr(pwmtu_pkg::ADDR_MODE, 16'h0040);
		wr(pwmtu_pkg::ADDR_HALF_PERIOD, 16'(tm));
		t0 = cyc;
		wr(pwmtu_pkg::ADDR_DUTY_A, 16'h0032);
		wr(pwmtu_pkg::ADDR_DUTY_B, 16'h0064);
		wr(pwmtu_pkg::ADDR_DUTY_C, 16'h0096);
		rise();
		chk("first sync double", (cyc - t0 >= 200) && (cyc - t0 <= 206), 1'b1);
		meas(2);
		chk("period double", per, 2 * tm);
		chk("sync width double", sw, 80);
		chk("shoot-through double", faults, 16'h0000);
		end_of_test();
	end
endmodule : pwmtu_timing_unit_test
bind pwmtu_timing_unit pwmtu_timing_unit_checker i_chk (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
	.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
	.period_sync_pulse_out(period_sync_pulse_out), .phase_a_high_out(phase_a_high_out),
	.phase_a_low_out(phase_a_low_out), .phase_b_high_out(phase_b_high_out),
	.phase_b_low_out(phase_b_low_out), .phase_c_high_out(phase_c_high_out), .phase_c_low_out(phase_c_low_out));
`default_nettype wire
